// ### hdl/lgc_pkg.sv
// Purpose: shared constants for the luma gain control register bank
// Assumes: 8-bit register port, 12-bit gain words
// Notes:   offsets are byte subaddresses of the register port
package lgc_pkg;

    localparam int unsigned GAIN_W = 12;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    typedef logic [GAIN_W-1:0] lgc_gain_t;
    typedef logic [DATA_W-1:0] lgc_byte_t;
    typedef logic [ADDR_W-1:0] lgc_addr_t;

    // subaddresses
    localparam lgc_addr_t ADDR_AGC_MODE_CONTROL    = 8'h2C;
    localparam lgc_addr_t ADDR_LUMA_GAIN_HIGH      = 8'h2F;
    localparam lgc_addr_t ADDR_LUMA_GAIN_LOW       = 8'h30;
    localparam lgc_addr_t ADDR_GAIN_SHADOW_CTRL_HI = 8'h31;
    localparam lgc_addr_t ADDR_GAIN_SHADOW_LOW     = 8'h32;
    localparam lgc_addr_t ADDR_MISC_GAIN_CONTROL   = 8'h33;

    // field positions
    localparam int unsigned POS_LUMA_AGC_MODE   = 4;   // D6-D4 of 0x2C
    localparam int unsigned POS_CHROMA_AGC_MODE = 0;   // D1-D0 of 0x2C
    localparam int unsigned POS_GAIN_HIGH       = 0;   // D3-D0 of 0x2F / 0x31
    localparam int unsigned POS_SHADOW_ENABLE   = 7;   // D7 of 0x31
    localparam int unsigned POS_COLOR_KILL_EN   = 6;   // D6 of 0x33
    localparam int unsigned POS_MAX_IRE         = 2;   // D4-D2 of 0x33
    localparam int unsigned POS_AVG_LINE_RANGE  = 1;   // D1 of 0x33
    localparam int unsigned POS_UPDATE_RATE     = 0;   // D0 of 0x33

    // reset values
    localparam logic [2:0] RST_LUMA_AGC_MODE   = 3'h0;
    localparam logic [1:0] RST_CHROMA_AGC_MODE = 2'h0;
    localparam lgc_gain_t  RST_MANUAL_GAIN     = 12'h000;
    localparam lgc_gain_t  RST_SHADOW_GAIN     = 12'h000;
    localparam logic       RST_SHADOW_ENABLE   = 1'b0;
    localparam logic       RST_COLOR_KILL_EN   = 1'b0;
    localparam logic [2:0] RST_MAX_IRE         = 3'h0;
    localparam logic       RST_AVG_LINE_RANGE  = 1'b0;
    localparam logic       RST_UPDATE_RATE     = 1'b0;

    // luma and chroma agc mode codes
    localparam logic [2:0] LUMA_AGC_MODE_MANUAL     = 3'h0;
    localparam logic [2:0] LUMA_AGC_MODE_PEAK_WHITE = 3'h5;
    localparam logic [2:0] LUMA_AGC_MODE_AVERAGE    = 3'h6;
    localparam logic [2:0] LUMA_AGC_MODE_FREEZE     = 3'h7;
    localparam logic [1:0] CHROMA_AGC_MODE_USE_LUMA   = 2'h1;

    // colour kill hysteresis, in consecutive video lines
    localparam int unsigned KILL_LINES = 128;

    // average brightness line windows
    localparam logic [9:0] AVG_LINE_FIRST  = 10'h021;   // line 33
    localparam logic [9:0] AVG_LINE_LAST_0 = 10'h136;   // line 310
    localparam logic [9:0] AVG_LINE_LAST_1 = 10'h10E;   // line 270

endpackage : lgc_pkg

// ### hdl/lgc_kill_if.sv
// Purpose: carries burst status and colour kill state between modules
// Assumes: single clock domain
// Notes:   line_tick is a one-cycle pulse per video line
`timescale 1ns/1ns
`default_nettype none
interface lgc_kill_if;
    logic enable;
    logic line_tick;
    logic burst_below;
    logic burst_above;
    logic kill;

    modport ctrl      (output enable, output line_tick, output burst_below, output burst_above, input kill);
    modport kill_unit (input enable, input line_tick, input burst_below, input burst_above, output kill);
endinterface : lgc_kill_if
`default_nettype wire

// ### hdl/lgc_color_kill.sv
// Purpose: colour kill with line-count hysteresis
// Assumes: burst_below / burst_above already compared against 22 percent
// Notes:   a single broken line restarts the count
`timescale 1ns/1ns
`default_nettype none
module lgc_color_kill
    import lgc_pkg::*;
#(
    parameter int unsigned LINES = KILL_LINES
) (
    input  wire logic     clk,
    input  wire logic     rstn,
    lgc_kill_if.kill_unit kif
);
    import lgc_pkg::*;

    localparam int unsigned CNT_W = $clog2(LINES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LINES - 1);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             kill_ff;
    logic             nxt_kill;
    logic             line_counts;
    logic             reached;

    // while killed we look for strong burst, otherwise for weak burst
    assign line_counts = kill_ff ? kif.burst_above : kif.burst_below;
    assign reached     = line_counts && (cnt_ff == CNT_LAST);

    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_kill = kill_ff;
        if (!kif.enable) begin
            nxt_cnt  = '0;
            nxt_kill = 1'b0;
        end else if (kif.line_tick) begin
            if (reached) begin
                nxt_cnt  = '0;
                nxt_kill = !kill_ff;
            end else if (line_counts) begin
                nxt_cnt = cnt_ff + CNT_W'(1);
            end else begin
                nxt_cnt = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff  <= '0;
            kill_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            kill_ff <= nxt_kill;
        end
    end

    assign kif.kill = kill_ff;

endmodule // lgc_color_kill
`default_nettype wire

// ### hdl/lgc_gain_regs.sv
// Purpose: luma gain control and readback registers of the video decoder
// Assumes: register port driven by the two-wire serial decoder on clk
// Notes:   agc loop arithmetic and burst measurement live outside
`timescale 1ns/1ns
`default_nettype none
// How it works
// - writing the 12-bit manual gain stores it for the luma path
// - manual gain drives the luma path only in manual mode
// - gain reads return the gain in use: manual or automatic
// - shadow enable bit D7 switches the shadow facility on or off
// - shadow gain holds a 12-bit next-source gain, writing it changes nothing live
// - shadow copies into manual gain on pin toggle, select change or reacquire
// - colour kill after 128 consecutive lines of burst below 22 percent
// - colour returns after 128 consecutive lines of burst above 22 percent
// - 3-bit field picks maximum input IRE level per standard
// - average window: lines 33 to 310, or 33 to 270
// - update rate bit D0: in modes 101 and 110, gain changes once per line or per field
// - shadow gain: high nibble at 0x31 D3-D0, low byte at 0x32
// - luma mode codes: 000 manual, 001-100 sync-tip, 101, 110, 111 freeze
// - chroma mode 01 makes chroma use the luma gain
module lgc_gain_regs
    import lgc_pkg::*;
#(
    parameter int unsigned SEL_W = 4
) (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire lgc_pkg::lgc_addr_t reg_addr,
    input  wire lgc_pkg::lgc_byte_t reg_wdata,
    output var  lgc_pkg::lgc_byte_t reg_rdata,
    output var  logic               reg_rvalid,
    input  wire logic               input_switch_pin,
    input  wire logic [SEL_W-1:0]   input_select,
    input  wire logic               reacquire_trigger,
    input  wire lgc_pkg::lgc_gain_t auto_gain,
    input  wire logic               line_tick,
    input  wire logic               field_tick,
    input  wire logic               burst_below,
    input  wire logic               burst_above,
    output var  lgc_pkg::lgc_gain_t luma_gain,
    output var  logic               chroma_uses_luma_gain,
    output var  logic               color_kill,
    output var  logic [7:0]         max_ire_pal,
    output var  logic [7:0]         max_ire_ntsc,
    output var  logic [9:0]         avg_line_first,
    output var  logic [9:0]         avg_line_last,
    output var  logic               gain_update_tick
);
    import lgc_pkg::*;

    // IRE limit per code; pal selects the PAL column
    function automatic logic [7:0] ire_limit(input logic [2:0] code, input logic pal);
        logic [7:0] v;
        v = 8'h64;
        case (code)
            3'h0: v = pal ? 8'h85 : 8'h7A;
            3'h1: v = pal ? 8'h7D : 8'h73;
            3'h2: v = pal ? 8'h78 : 8'h6E;
            3'h3: v = pal ? 8'h73 : 8'h69;
            3'h4: v = pal ? 8'h6E : 8'h64;
            3'h5: v = pal ? 8'h69 : 8'h64;
            default: v = 8'h64;
        endcase
        return v;
    endfunction

    // register state
    logic [2:0]  luma_agc_mode_ff;
    logic [1:0]  chroma_agc_mode_ff;
    lgc_gain_t   luma_manual_gain_ff;
    lgc_gain_t   luma_gain_shadow_ff;
    logic        shadow_gain_update_enable_ff;
    logic        color_kill_enable_ff;
    logic [2:0]  max_input_level_select_ff;
    logic        average_line_range_select_ff;
    logic        gain_update_rate_ff;
    lgc_gain_t   luma_gain_in_use_ff;
    lgc_byte_t   rdata_ff;
    logic        rvalid_ff;
    logic        chroma_follow_ff;
    logic [7:0]  ire_pal_ff;
    logic [7:0]  ire_ntsc_ff;
    logic [9:0]  avg_last_ff;
    logic        upd_tick_ff;

    // source switch detection
    logic             pin_meta_ff;
    logic             pin_sync_ff;
    logic             pin_prev_ff;
    logic [SEL_W-1:0] sel_prev_ff;

    // next values
    lgc_gain_t   nxt_manual;
    lgc_gain_t   nxt_gain_in_use;
    lgc_byte_t   nxt_rdata;

    // decode
    logic wr_agc;
    logic wr_gain_hi;
    logic wr_gain_lo;
    logic wr_shadow_hi;
    logic wr_shadow_lo;
    logic wr_misc;
    logic source_event;
    logic shadow_copy;
    logic manual_mode;
    logic measured_mode;
    logic rate_tick;

    assign wr_agc       = reg_wr && (reg_addr == ADDR_AGC_MODE_CONTROL);
    assign wr_gain_hi   = reg_wr && (reg_addr == ADDR_LUMA_GAIN_HIGH);
    assign wr_gain_lo   = reg_wr && (reg_addr == ADDR_LUMA_GAIN_LOW);
    assign wr_shadow_hi = reg_wr && (reg_addr == ADDR_GAIN_SHADOW_CTRL_HI);
    assign wr_shadow_lo = reg_wr && (reg_addr == ADDR_GAIN_SHADOW_LOW);
    assign wr_misc      = reg_wr && (reg_addr == ADDR_MISC_GAIN_CONTROL);

    // pin edge and select change count alike as a source switch
    assign source_event = (pin_sync_ff != pin_prev_ff)
                        || (input_select != sel_prev_ff)
                        || reacquire_trigger;
    assign shadow_copy  = shadow_gain_update_enable_ff && source_event;

    assign manual_mode   = (luma_agc_mode_ff == LUMA_AGC_MODE_MANUAL);
    assign measured_mode = (luma_agc_mode_ff == LUMA_AGC_MODE_PEAK_WHITE)
                        || (luma_agc_mode_ff == LUMA_AGC_MODE_AVERAGE);
    assign rate_tick     = gain_update_rate_ff ? field_tick : line_tick;

    // host writes beat a shadow copy in the same cycle; copy still lands on the untouched half
    always_comb begin
        nxt_manual = luma_manual_gain_ff;
        if (shadow_copy) begin
            nxt_manual = luma_gain_shadow_ff;
        end
        if (wr_gain_hi) begin
            nxt_manual[GAIN_W-1:8] = reg_wdata[POS_GAIN_HIGH +: 4];
        end
        if (wr_gain_lo) begin
            nxt_manual[7:0] = reg_wdata;
        end
    end

    // gain actually applied to the luma path
    always_comb begin
        nxt_gain_in_use = luma_gain_in_use_ff;
        if (manual_mode) begin
            nxt_gain_in_use = luma_manual_gain_ff;
        end else if (luma_agc_mode_ff == LUMA_AGC_MODE_FREEZE) begin
            nxt_gain_in_use = luma_gain_in_use_ff;
        end else if (measured_mode) begin
            if (rate_tick) begin
                nxt_gain_in_use = auto_gain;
            end
        end else begin
            nxt_gain_in_use = auto_gain;
        end
    end

    // readback; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            ADDR_AGC_MODE_CONTROL: begin
                nxt_rdata[POS_LUMA_AGC_MODE +: 3]   = luma_agc_mode_ff;
                nxt_rdata[POS_CHROMA_AGC_MODE +: 2] = chroma_agc_mode_ff;
            end
            ADDR_LUMA_GAIN_HIGH: begin
                nxt_rdata[POS_GAIN_HIGH +: 4] = luma_gain_in_use_ff[GAIN_W-1:8];
            end
            ADDR_LUMA_GAIN_LOW: begin
                nxt_rdata = luma_gain_in_use_ff[7:0];
            end
            ADDR_GAIN_SHADOW_CTRL_HI: begin
                nxt_rdata[POS_SHADOW_ENABLE]  = shadow_gain_update_enable_ff;
                nxt_rdata[POS_GAIN_HIGH +: 4] = luma_gain_shadow_ff[GAIN_W-1:8];
            end
            ADDR_GAIN_SHADOW_LOW: begin
                nxt_rdata = luma_gain_shadow_ff[7:0];
            end
            ADDR_MISC_GAIN_CONTROL: begin
                nxt_rdata[POS_COLOR_KILL_EN]  = color_kill_enable_ff;
                nxt_rdata[POS_MAX_IRE +: 3]   = max_input_level_select_ff;
                nxt_rdata[POS_AVG_LINE_RANGE] = average_line_range_select_ff;
                nxt_rdata[POS_UPDATE_RATE]    = gain_update_rate_ff;
            end
            default: nxt_rdata = 8'h00;
        endcase
    end

    // control registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            luma_agc_mode_ff   <= RST_LUMA_AGC_MODE;
            chroma_agc_mode_ff <= RST_CHROMA_AGC_MODE;
        end else if (wr_agc) begin
            luma_agc_mode_ff   <= reg_wdata[POS_LUMA_AGC_MODE +: 3];
            chroma_agc_mode_ff <= reg_wdata[POS_CHROMA_AGC_MODE +: 2];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            luma_manual_gain_ff <= RST_MANUAL_GAIN;
        end else begin
            luma_manual_gain_ff <= nxt_manual;
        end
    end

    // shadow writes never touch the live gain
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            luma_gain_shadow_ff          <= RST_SHADOW_GAIN;
            shadow_gain_update_enable_ff <= RST_SHADOW_ENABLE;
        end else begin
            if (wr_shadow_hi) begin
                shadow_gain_update_enable_ff     <= reg_wdata[POS_SHADOW_ENABLE];
                luma_gain_shadow_ff[GAIN_W-1:8]  <= reg_wdata[POS_GAIN_HIGH +: 4];
            end
            if (wr_shadow_lo) begin
                luma_gain_shadow_ff[7:0] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            color_kill_enable_ff         <= RST_COLOR_KILL_EN;
            max_input_level_select_ff    <= RST_MAX_IRE;
            average_line_range_select_ff <= RST_AVG_LINE_RANGE;
            gain_update_rate_ff          <= RST_UPDATE_RATE;
        end else if (wr_misc) begin
            color_kill_enable_ff         <= reg_wdata[POS_COLOR_KILL_EN];
            max_input_level_select_ff    <= reg_wdata[POS_MAX_IRE +: 3];
            average_line_range_select_ff <= reg_wdata[POS_AVG_LINE_RANGE];
            gain_update_rate_ff          <= reg_wdata[POS_UPDATE_RATE];
        end
    end

    // pin is asynchronous: two flops before the edge detector
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
            sel_prev_ff <= '0;
        end else begin
            pin_meta_ff <= input_switch_pin;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
            sel_prev_ff <= input_select;
        end
    end

    // status and derived outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            luma_gain_in_use_ff <= RST_MANUAL_GAIN;
            rdata_ff            <= 8'h00;
            rvalid_ff           <= 1'b0;
            chroma_follow_ff    <= 1'b0;
            ire_pal_ff          <= 8'h00;
            ire_ntsc_ff         <= 8'h00;
            avg_last_ff         <= AVG_LINE_LAST_0;
            upd_tick_ff         <= 1'b0;
        end else begin
            luma_gain_in_use_ff <= nxt_gain_in_use;
            rdata_ff            <= reg_rd ? nxt_rdata : rdata_ff;
            rvalid_ff           <= reg_rd;
            chroma_follow_ff    <= (chroma_agc_mode_ff == CHROMA_AGC_MODE_USE_LUMA);
            ire_pal_ff          <= ire_limit(max_input_level_select_ff, 1'b1);
            ire_ntsc_ff         <= ire_limit(max_input_level_select_ff, 1'b0);
            avg_last_ff         <= average_line_range_select_ff ? AVG_LINE_LAST_1
                                                                : AVG_LINE_LAST_0;
            upd_tick_ff         <= measured_mode && rate_tick;
        end
    end

    lgc_kill_if kif ();

    assign kif.enable      = color_kill_enable_ff;
    assign kif.line_tick   = line_tick;
    assign kif.burst_below = burst_below;
    assign kif.burst_above = burst_above;

    lgc_color_kill #(
        .LINES (KILL_LINES)
    ) u_color_kill (
        .clk  (clk),
        .rstn (rstn),
        .kif  (kif.kill_unit)
    );

    assign reg_rdata             = rdata_ff;
    assign reg_rvalid            = rvalid_ff;
    assign luma_gain             = luma_gain_in_use_ff;
    assign chroma_uses_luma_gain = chroma_follow_ff;
    assign color_kill            = kif.kill;
    assign max_ire_pal           = ire_pal_ff;
    assign max_ire_ntsc          = ire_ntsc_ff;
    assign avg_line_first        = AVG_LINE_FIRST;
    assign avg_line_last         = avg_last_ff;
    assign gain_update_tick      = upd_tick_ff;

endmodule // lgc_gain_regs
`default_nettype wire

// ### test/lgc_gain_regs_checker.sv
// Purpose: port checks for the gain registers
// Assumes: one clock, rstn asynchronous active low
// Notes:   bound into lgc_gain_regs
`timescale 1ns/1ns
`default_nettype none
module lgc_gain_regs_checker (
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire lgc_pkg::lgc_addr_t reg_addr,
    input wire lgc_pkg::lgc_byte_t reg_rdata,
    input wire logic               reg_rvalid,
    input wire lgc_pkg::lgc_gain_t auto_gain,
    input wire logic               line_tick,
    input wire logic               field_tick,
    input wire lgc_pkg::lgc_gain_t luma_gain,
    input wire logic               chroma_uses_luma_gain,
    input wire logic               color_kill,
    input wire logic [7:0]         max_ire_pal,
    input wire logic [7:0]         max_ire_ntsc,
    input wire logic [9:0]         avg_line_first,
    input wire logic [9:0]         avg_line_last,
    input wire logic               gain_update_tick
);
    import lgc_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no valid pulse");
    gain_low_read_a: assert property (reg_rd && reg_addr == ADDR_LUMA_GAIN_LOW
        |=> reg_rdata == 8'($past(luma_gain)))
        else $error("low gain read wrong");
    gain_high_read_a: assert property (reg_rd && reg_addr == ADDR_LUMA_GAIN_HIGH
        |=> reg_rdata == {4'h0, 4'($past(luma_gain) >> 8)})
        else $error("high gain read wrong");
    kill_on_line_a: assert property ($changed(color_kill) |-> $past(line_tick) || $past(reg_wr, 2))
        else $error("kill moved off a line");
    ire_pair_a: assert property (max_ire_pal != 8'h00 |-> {max_ire_pal, max_ire_ntsc} inside
        {16'h857A, 16'h7D73, 16'h786E, 16'h7369, 16'h6E64, 16'h6964, 16'h6464})
        else $error("ire pair not in table");
    avg_window_a: assert property (avg_line_first == AVG_LINE_FIRST
        && (avg_line_last == AVG_LINE_LAST_0 || avg_line_last == AVG_LINE_LAST_1))
        else $error("bad average window");
    update_on_tick_a: assert property (gain_update_tick |-> $past(line_tick) || $past(field_tick))
        else $error("update without tick");
    update_takes_auto_a: assert property (gain_update_tick |-> luma_gain == $past(auto_gain))
        else $error("update missed auto gain");
    chroma_follow_a: assert property ($rose(chroma_uses_luma_gain) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("chroma follow without write");
endmodule // lgc_gain_regs_checker
bind lgc_gain_regs lgc_gain_regs_checker chk (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid,
    .auto_gain, .line_tick, .field_tick, .luma_gain, .chroma_uses_luma_gain, .color_kill, .max_ire_pal,
    .max_ire_ntsc, .avg_line_first, .avg_line_last, .gain_update_tick);
`default_nettype wire

// ### test/lgc_host_model.sv
// Purpose: host side of the register strobe port
// Assumes: requests launched at the falling edge
// Notes:   released address and data show the inverse
`timescale 1ns/1ns
`default_nettype none
module lgc_host_model (
    input  wire logic               clk,
    output var  logic               reg_wr,
    output var  logic               reg_rd,
    output var  lgc_pkg::lgc_addr_t reg_addr,
    output var  lgc_pkg::lgc_byte_t reg_wdata,
    input  wire lgc_pkg::lgc_byte_t reg_rdata,
    input  wire logic               reg_rvalid
);
    import lgc_pkg::*;

    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;

    // one-cycle write strobe; address and data driven inverted on release
    task automatic wr(input lgc_addr_t a, input lgc_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input lgc_addr_t a, output lgc_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // lgc_host_model
`default_nettype wire

// ### test/lgc_gain_regs_bench.sv
// Purpose: self-checking bench for lgc_gain_regs
// Assumes: inputs change at the falling edge
// Notes:   one task per scenario
`timescale 1ns/1ns
`default_nettype none
module lgc_gain_regs_bench;
    import lgc_pkg::*;

    logic clk = 1'b0, rstn = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, pin = 1'b0, reacq = 1'b0, line_tick = 1'b0, field_tick = 1'b0;
    logic below = 1'b0, above = 1'b0, chroma_lg, color_kill, upd;
    logic [3:0] sel = 4'h0;
    lgc_addr_t reg_addr;
    lgc_byte_t reg_wdata, reg_rdata;
    lgc_gain_t auto_gain = 12'h000, luma_gain;
    logic [7:0] ire_p, ire_n;
    logic [9:0] first, last;
    int fails = 0;
    int num_checks = 0;
    logic [7:0] pal[8] = '{8'h85, 8'h7D, 8'h78, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64};
    logic [7:0] ntsc[8] = '{8'h7A, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64, 8'h64, 8'h64};

    always #50 clk = ~clk;

    lgc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    lgc_gain_regs uut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .input_switch_pin(pin),
        .input_select(sel), .reacquire_trigger(reacq), .auto_gain(auto_gain), .line_tick(line_tick),
        .field_tick(field_tick), .burst_below(below), .burst_above(above), .luma_gain(luma_gain),
        .chroma_uses_luma_gain(chroma_lg), .color_kill(color_kill), .max_ire_pal(ire_p),
        .max_ire_ntsc(ire_n), .avg_line_first(first), .avg_line_last(last), .gain_update_tick(upd));

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_reg(input lgc_addr_t a, input lgc_byte_t exp);
        lgc_byte_t d;
        host.rd(a, d);
        chk($sformatf("reg %h", a), {4'h0, exp}, {4'h0, d});
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic line(input logic b, input logic a);
        @(negedge clk);
        line_tick = 1'b1;
        below = b;
        above = a;
        @(negedge clk);
        line_tick = 1'b0;
    endtask

    task automatic t_manual();
        for (int i = 0; i < 6; i++) chk_reg(8'h2C + 8'(i) + ((i > 0) ? 8'h02 : 8'h00), 8'h00);
        chk_reg(8'h40, 8'h00);
        host.wr(ADDR_AGC_MODE_CONTROL, 8'h00);
        host.wr(ADDR_LUMA_GAIN_HIGH, 8'hFA);
        host.wr(ADDR_LUMA_GAIN_LOW, 8'hBC);
        wait_n(2);
        chk("manual gain", 12'hABC, luma_gain);
        chk_reg(ADDR_LUMA_GAIN_HIGH, 8'h0A);
        chk_reg(ADDR_LUMA_GAIN_LOW, 8'hBC);
        $display("t_manual done");
    endtask

    task automatic t_auto();
        auto_gain = 12'h5A5;
        for (int m = 1; m <= 4; m++) begin
            host.wr(ADDR_AGC_MODE_CONTROL, {1'b0, 3'(m), 4'h0});
            wait_n(2);
            chk("sync tip gain", 12'h5A5, luma_gain);
        end
        chk_reg(ADDR_LUMA_GAIN_LOW, 8'hA5);
        host.wr(ADDR_AGC_MODE_CONTROL, 8'h70);
        auto_gain = 12'h111;
        wait_n(3);
        chk("frozen gain", 12'h5A5, luma_gain);
        host.wr(ADDR_AGC_MODE_CONTROL, 8'h00);
        wait_n(3);
        chk("manual again", 12'hABC, luma_gain);
        $display("t_auto done");
    endtask

    task automatic t_peak();
        lgc_gain_t prev = 12'hABC;
        for (int m = 5; m <= 6; m++) begin
            host.wr(ADDR_AGC_MODE_CONTROL, {1'b0, 3'(m), 4'h0});
            host.wr(ADDR_MISC_GAIN_CONTROL, 8'h00);
            auto_gain = 12'h2C0 + 12'(m);
            wait_n(2);
            chk("no tick", prev, luma_gain);
            line(1'b0, 1'b0);
            chk("line rate", 12'h2C0 + 12'(m), luma_gain);
            host.wr(ADDR_MISC_GAIN_CONTROL, 8'h01);
            auto_gain = 12'h3C0 + 12'(m);
            line(1'b0, 1'b0);
            chk("field rate line", 12'h2C0 + 12'(m), luma_gain);
            @(negedge clk);
            field_tick = 1'b1;
            @(negedge clk);
            field_tick = 1'b0;
            chk("field rate", 12'h3C0 + 12'(m), luma_gain);
            prev = luma_gain;
        end
        $display("t_peak done");
    endtask

    task automatic t_shadow();
        host.wr(ADDR_AGC_MODE_CONTROL, 8'h00);
        host.wr(ADDR_GAIN_SHADOW_CTRL_HI, 8'h73);
        host.wr(ADDR_GAIN_SHADOW_LOW, 8'h21);
        chk_reg(ADDR_GAIN_SHADOW_CTRL_HI, 8'h03);
        chk_reg(ADDR_GAIN_SHADOW_LOW, 8'h21);
        reacq = 1'b1;
        sel = 4'h1;
        pin = 1'b1;
        @(negedge clk);
        reacq = 1'b0;
        wait_n(6);
        chk("shadow off", 12'hABC, luma_gain);
        host.wr(ADDR_GAIN_SHADOW_CTRL_HI, 8'h83);
        wait_n(3);
        chk("shadow stored", 12'hABC, luma_gain);
        reacq = 1'b1;
        @(negedge clk);
        reacq = 1'b0;
        wait_n(3);
        chk("reacquire copy", 12'h321, luma_gain);
        host.wr(ADDR_GAIN_SHADOW_LOW, 8'h54);
        sel = 4'h2;
        wait_n(3);
        chk("select copy", 12'h354, luma_gain);
        host.wr(ADDR_GAIN_SHADOW_LOW, 8'hFF);
        pin = 1'b0;
        wait_n(7);
        chk("pin copy", 12'h3FF, luma_gain);
        $display("t_shadow done");
    endtask

    task automatic t_kill();
        host.wr(ADDR_MISC_GAIN_CONTROL, 8'h40);
        repeat (127) line(1'b1, 1'b0);
        chk("kill early", 12'h000, 12'(color_kill));
        line(1'b1, 1'b0);
        chk("kill", 12'h001, 12'(color_kill));
        repeat (100) line(1'b0, 1'b1);
        line(1'b0, 1'b0);
        repeat (127) line(1'b0, 1'b1);
        chk("restore early", 12'h001, 12'(color_kill));
        line(1'b0, 1'b1);
        chk("restore", 12'h000, 12'(color_kill));
        $display("t_kill done");
    endtask

    task automatic t_misc();
        for (int c = 0; c < 8; c++) begin
            host.wr(ADDR_MISC_GAIN_CONTROL, {3'h0, 3'(c), 2'h0});
            wait_n(2);
            chk("ire pal", 12'(pal[c]), 12'(ire_p));
            chk("ire ntsc", 12'(ntsc[c]), 12'(ire_n));
        end
        chk("avg last 0", 12'h136, 12'(last));
        host.wr(ADDR_MISC_GAIN_CONTROL, 8'hFF);
        wait_n(2);
        chk("avg last 1", 12'h10E, 12'(last));
        chk_reg(ADDR_MISC_GAIN_CONTROL, 8'h5F);
        host.wr(ADDR_AGC_MODE_CONTROL, 8'h21);
        wait_n(3);
        chk("chroma follows", 12'h001, 12'(chroma_lg));
        host.wr(ADDR_AGC_MODE_CONTROL, 8'h22);
        wait_n(3);
        chk("chroma own", 12'h000, 12'(chroma_lg));
        $display("t_misc done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial begin
        wait_n(6);
        rstn = 1'b1;
        t_manual();
        t_auto();
        t_peak();
        t_shadow();
        t_kill();
        t_misc();
        stop_test();
    end
endmodule // lgc_gain_regs_bench
`default_nettype wire
